// File: logic/feature_detect_regs.svh
// register offsets, field positions and reset values of the feature block
// assumes inclusion from the design modules and the testbench
`ifndef FEATURE_DETECT_REGS_SVH
`define FEATURE_DETECT_REGS_SVH

// word offsets on the register port
`define ADDR_FLAGS 8'h00
`define ADDR_QUERY_D 8'h04
`define ADDR_QUERY_A 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_FAULT_CNT 8'h14
`define ADDR_VEC_CSR 8'h18
// vector register window: addr bit 7 set, reg in [6:4], word in [3:2]
`define VREG_SEL_BIT 3'h7

// flags register field positions
`define FLAG_ALIGN 5'h12
`define FLAG_VINT 5'h13
`define FLAG_VPEND 5'h14
`define FLAG_GATE 5'h15
`define FLAG_PLAIN_MASK 32'h0003_FFFF

// feature-query result d bit positions
`define QD_FPU 5'h00
`define QD_TSC 5'h04
`define QD_MODEL 5'h05
`define QD_CX8 5'h08
`define QD_CMOV 5'h0F
`define QD_PACKED 5'h17
`define QD_VEC1 5'h19
`define QD_VEC2 5'h1A
`define QD_VEC3 5'h1B

// feature-query result a: family field lsb, and the family that
// carries the counter read and the undefined op (value arbitrary)
`define QA_FAMILY_LSB 5'h08
`define PERF_FAMILY 4'hA

// third vector extension: number of instructions
`define VEC3_COUNT 4'hD

// sticky status bit positions
`define ST_FAULT 2'h0
`define ST_TESTREG 2'h1
`define ST_GATE 2'h2

// reset values
`define FLAGS_RST 32'h0000_0000
`define STATUS_RST 3'h0
`define MASK_RST 3'h0
`define CNT_RST 16'h0000
`define VEC_CSR_RST 32'h0000_0000
`define VREG_RST 128'h0
`define RDATA_RST 32'h0000_0000

`endif

// File: logic/feature_detect_pkg.sv
// types shared by the feature block and its opcode classifier
// assumes the constants header sits beside it
package feature_detect_pkg;

    // instruction classes handed to the decoder
    typedef enum logic [4:0] {
        OPC_BASE,
        OPC_RESERVED,
        OPC_CMOV,
        OPC_FLOAT_CONDITIONAL_MOVE,
        OPC_FLOAT_COMPARE_TO_FLAGS,
        OPC_PERF_READ,
        OPC_UNDEF_OP,
        OPC_CMPXCHG8,
        OPC_QUERY,
        OPC_TSC,
        OPC_MODEL_RD,
        OPC_MODEL_WR,
        OPC_PACKED_INT,
        OPC_TEST_REG_MOV,
        OPC_VEC1,
        OPC_VEC2,
        OPC_VEC3
    } op_class_t;

    // one decode request
    typedef struct packed {
        logic valid;
        op_class_t cls;
        logic [3:0] sub;
    } dec_req_t;

    // one decode answer
    typedef struct packed {
        logic valid;
        logic fault;
        logic exec;
    } dec_res_t;

endpackage

// File: logic/opcode_classifier.sv
// combinational legality check of one instruction class
// assumes the feature vector and gates are stable configuration
`timescale 1ns/1ns
`include "feature_detect_regs.svh"

module opcode_classifier
    import feature_detect_pkg::*;
(
    input wire op_class_t cls,
    input wire logic [3:0] sub,
    input wire logic [31:0] cap_d,
    input wire logic family_ok,
    input wire logic has_query,
    input wire logic perf_model,
    output logic legal,
    output logic test_reg
);

    // per class: is the encoding executable on this core
    always_comb
    begin
        legal = 1'b0;
        test_reg = 1'b0;
        unique case (cls)
            OPC_BASE: legal = 1'b1;
            OPC_RESERVED: legal = 1'b0;
            OPC_CMOV: legal = cap_d[`QD_CMOV];
            // float forms need bits 0 and 15
            OPC_FLOAT_CONDITIONAL_MOVE, OPC_FLOAT_COMPARE_TO_FLAGS:
                legal = cap_d[`QD_FPU] & cap_d[`QD_CMOV];
            OPC_PERF_READ: legal = family_ok & perf_model;
            // always faults, by its own definition
            OPC_UNDEF_OP: legal = 1'b0;
            OPC_CMPXCHG8: legal = cap_d[`QD_CX8];
            OPC_QUERY: legal = has_query;
            OPC_TSC: legal = cap_d[`QD_TSC];
            OPC_MODEL_RD, OPC_MODEL_WR: legal = cap_d[`QD_MODEL];
            OPC_PACKED_INT: legal = cap_d[`QD_PACKED];
            OPC_TEST_REG_MOV:
            begin
                legal = 1'b0;
                test_reg = 1'b1;
            end
            OPC_VEC1: legal = cap_d[`QD_VEC1];
            OPC_VEC2: legal = cap_d[`QD_VEC1] & cap_d[`QD_VEC2];
            OPC_VEC3: legal = cap_d[`QD_VEC3] && (sub < `VEC3_COUNT);
            // unknown class codes are reserved
            default: legal = 1'b0;
        endcase
    end

endmodule

// File: logic/feature_detect_and_opcode_trap.sv
// feature presence, flags register and invalid-opcode trap of the core
// assumes a one-clock register master and a decode stage on clk
//
// Functional notes
// - reserved encodings raise the invalid-opcode fault
// - test-register moves trap, never execute
// - flags bits 19, 20, 21 hold virtual, pending, gate
// - gate flag toggles only with feature query
// - alignment flag bit 18 reads clear if absent
// - virtual interrupt bits read zero without extensions
// - bits 8, 4, 5, 23 report their instructions
// - family bits 8-11 gate counter read; undefined op always faults
// - eight 128-bit vector registers plus control word
// - third vector extension holds thirteen instructions
`timescale 1ns/1ns
`include "feature_detect_regs.svh"

module feature_detect_and_opcode_trap
    import feature_detect_pkg::*;
#(
    // feature-query result d as this core reports it
    parameter logic [31:0] CAP_D = 32'h0E80_8131,
    // presence of the feature query, alignment check, virtual mode
    parameter logic HAS_QUERY = 1'h1,
    parameter logic HAS_ALIGN = 1'h1,
    parameter logic HAS_VME = 1'h1,
    // counter read implemented on this model
    parameter logic PERF_MODEL = 1'h1,
    // family code, value arbitrary
    parameter logic [3:0] FAMILY = 4'hA
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire dec_req_t dec_req,
    output dec_res_t dec_res,
    output logic irq
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [31:0] flags_r; // flags register
    logic [31:0] flags_nxt;
    logic [2:0] status_r; // sticky events
    logic [2:0] mask_r; // interrupt enables
    logic [15:0] fault_cnt_r; // faults raised so far
    logic [31:0] vec_csr_r; // vector control and status
    logic [127:0] vreg_r [8]; // vector registers
    logic [31:0] rdata_r; // read answer
    dec_res_t res_r; // decode answer
    logic [31:0] query_a; // feature-query result a
    logic family_ok; // family carries counter read
    logic legal; // classifier verdict
    logic test_reg; // request is a test-register move
    logic [31:0] impl_mask;
    logic vreg_hit; // address falls in vector window
    logic [2:0] vreg_sel;
    logic [1:0] vword_sel;
    logic fault_now; // fault raised this cycle
    logic gate_change; // software toggled the gate flag
    logic [2:0] status_set;
    logic [2:0] status_clr;

    assign query_a = 32'(FAMILY) << `QA_FAMILY_LSB;
    assign family_ok = (FAMILY == `PERF_FAMILY);

    // vector window decode
    assign vreg_hit = addr[`VREG_SEL_BIT];
    assign vreg_sel = addr[6:4];
    assign vword_sel = addr[3:2];

    // legality of the current request
    opcode_classifier u_classify (
        .cls(dec_req.cls),
        .sub(dec_req.sub),
        .cap_d(CAP_D),
        .family_ok(family_ok),
        .has_query(HAS_QUERY),
        .perf_model(PERF_MODEL),
        .legal(legal),
        .test_reg(test_reg)
    );

    // implemented flag bits; absent ones never store
    always_comb
    begin
        impl_mask = `FLAG_PLAIN_MASK;
        impl_mask[`FLAG_ALIGN] = HAS_ALIGN;
        impl_mask[`FLAG_VINT] = HAS_VME;
        impl_mask[`FLAG_VPEND] = HAS_VME;
        // gate flag only with feature query
        impl_mask[`FLAG_GATE] = HAS_QUERY;
    end

    // next flags value on a software write
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr && addr == `ADDR_FLAGS)
        begin
            // bits land at 19, 20, 21
            flags_nxt = wdata & impl_mask;
        end
    end

    // flags register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_r <= `FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    // software changed the gate flag
    assign gate_change = flags_nxt[`FLAG_GATE] != flags_r[`FLAG_GATE];

    // decode answer, one cycle after the request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            res_r <= '0;
        else
        begin
            res_r.valid <= dec_req.valid;
            res_r.fault <= dec_req.valid & ~legal;
            res_r.exec <= dec_req.valid & legal;
        end
    end
    assign dec_res = res_r;
    assign fault_now = dec_req.valid & ~legal;

    // fault counter, wraps
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fault_cnt_r <= `CNT_RST;
        else if (fault_now)
            fault_cnt_r <= fault_cnt_r + 16'h0001;
    end

    // sticky event sources and one-to-clear writes
    always_comb
    begin
        status_set = '0;
        status_set[`ST_FAULT] = fault_now;
        // test-register trap is its own event
        status_set[`ST_TESTREG] = dec_req.valid & test_reg;
        status_set[`ST_GATE] = gate_change;
        status_clr = '0;
        if (wr && addr == `ADDR_STATUS)
            status_clr = wdata[2:0];
    end

    // status: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            status_r <= `STATUS_RST;
        else
            status_r <= (status_r & ~status_clr) | status_set;
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_r <= `MASK_RST;
        else if (wr && addr == `ADDR_MASK)
            mask_r <= wdata[2:0];
    end

    // level interrupt while an enabled event stands
    assign irq = |(status_r & mask_r);

    // 32-bit control word of the vector unit
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            vec_csr_r <= `VEC_CSR_RST;
        else if (wr && addr == `ADDR_VEC_CSR && CAP_D[`QD_VEC1])
            vec_csr_r <= wdata;
    end

    for (genvar g = 0; g < 8; g++)
    begin : g_vreg
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                vreg_r[g] <= `VREG_RST;
            else if (wr && vreg_hit && vreg_sel == 3'(g)
                     && CAP_D[`QD_VEC1])
                vreg_r[g][32*vword_sel +: 32] <= wdata;
        end
    end

    // read mux; unmapped addresses answer zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= `RDATA_RST;
        else if (!rd)
            rdata_r <= `RDATA_RST;
        else if (vreg_hit)
            rdata_r <= CAP_D[`QD_VEC1]
                       ? vreg_r[vreg_sel][32*vword_sel +: 32]
                       : `RDATA_RST;
        else
        begin
            unique case (addr)
                `ADDR_FLAGS: rdata_r <= flags_r;
                `ADDR_QUERY_D: rdata_r <= CAP_D;
                `ADDR_QUERY_A: rdata_r <= query_a;
                `ADDR_STATUS: rdata_r <= 32'(status_r);
                `ADDR_MASK: rdata_r <= 32'(mask_r);
                `ADDR_FAULT_CNT: rdata_r <= 32'(fault_cnt_r);
                `ADDR_VEC_CSR: rdata_r <= vec_csr_r;
                default: rdata_r <= `RDATA_RST;
            endcase
        end
    end
    assign rdata = rdata_r;

    // reserved encodings answer with a fault
    a_reserved_fault:
    assert property (dec_req.valid && dec_req.cls == OPC_RESERVED
                     |=> dec_res.valid && dec_res.fault && !dec_res.exec)
    else $error("reserved encoding not trapped");

    // test-register moves fault and mark the status
    a_testreg_trap:
    assert property (dec_req.valid && dec_req.cls == OPC_TEST_REG_MOV
                     |=> dec_res.fault && status_r[`ST_TESTREG])
    else $error("test-register move not trapped");

    // a flags write read back shows the same three bits where implemented
    a_flag_layout:
    assert property (wr && addr == `ADDR_FLAGS ##1 !wr
                     ##1 rd && addr == `ADDR_FLAGS
                     |=> rdata[21:19] == ($past(wdata[21:19], 3)
                                          & impl_mask[21:19]))
    else $error("flag bits misplaced");

    // gate flag follows writes only with the query present
    a_gate_toggle:
    assert property (wr && addr == `ADDR_FLAGS
                     |=> flags_r[`FLAG_GATE]
                         == (HAS_QUERY & $past(wdata[`FLAG_GATE])))
    else $error("gate flag toggle wrong");

    // absent alignment flag never sets
    a_align_clear:
    assert property (!HAS_ALIGN |-> !flags_r[`FLAG_ALIGN])
    else $error("absent alignment flag set");

    // virtual bits stay zero without the extensions
    a_vme_zero:
    assert property (!HAS_VME |-> flags_r[20:19] == 2'h0)
    else $error("virtual flags not zero");

    // float conditional move needs bits 0 and 15
    a_float_gate:
    assert property (dec_req.valid && dec_req.cls == OPC_FLOAT_CONDITIONAL_MOVE
                     |=> dec_res.exec
                         == (CAP_D[`QD_FPU] && CAP_D[`QD_CMOV]))
    else $error("float conditional move gating wrong");

    // query result d reads back the report
    a_query_bits:
    assert property (rd && addr == `ADDR_QUERY_D |=> rdata == CAP_D)
    else $error("query result d wrong");

    // counter read follows the family code
    a_perf_family:
    assert property (dec_req.valid && dec_req.cls == OPC_PERF_READ
                     |=> dec_res.exec == (family_ok && PERF_MODEL)
                         && rdata_r == rdata)
    else $error("counter read gating wrong");

    // a vector word written is read back
    a_vreg_store:
    assert property (wr && vreg_hit && CAP_D[`QD_VEC1] ##1 !wr
                     ##1 rd && addr == $past(addr, 2)
                     |=> rdata == $past(wdata, 3))
    else $error("vector register lost data");

    // sub-codes thirteen and up are reserved
    a_vec3_count:
    assert property (dec_req.valid && dec_req.cls == OPC_VEC3
                     && dec_req.sub >= `VEC3_COUNT |=> dec_res.fault)
    else $error("third extension overflow executed");

    // absent feature behaves as reserved
    a_absent_trap:
    assert property (dec_req.valid && dec_req.cls == OPC_TSC
                     && !CAP_D[`QD_TSC] |=> dec_res.fault
                     && status_r[`ST_FAULT])
    else $error("absent feature executed");

    // main scenarios
    c_reserved: cover property (dec_req.valid && !legal ##1 dec_res.fault);
    c_query_run: cover property (dec_req.valid
                                 && dec_req.cls == OPC_QUERY ##1
                                 dec_res.exec);
    c_gate_flip: cover property (gate_change ##1 status_r[`ST_GATE]);
    c_irq_rise: cover property (!irq ##1 irq);

endmodule

// File: verif/tb_feature_detect_and_opcode_trap.sv
// self-checking bench for the feature block and its opcode trap
// assumes the design package and constants header are compiled first
`timescale 1ns/1ns
`include "feature_detect_regs.svh"

module tb_feature_detect_and_opcode_trap
    import feature_detect_pkg::*;
;
    logic clk; // 125 MHz core clock
    logic rst_b; // active-low reset
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata_full; // core with every feature
    logic [31:0] rdata_bare; // core with no optional feature
    dec_req_t dec_req;
    dec_res_t res_full;
    dec_res_t res_bare;
    logic irq_full;
    logic irq_bare;
    int err_total; // mismatches seen
    int check_count; // comparisons made
    int cycle_cnt = 0; // hang guard
    logic [9:0] tab [18]; // {legal, class, sub}

    // fully featured core, default configuration
    feature_detect_and_opcode_trap u_feature_detect_and_opcode_trap (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata_full), .dec_req(dec_req),
        .dec_res(res_full), .irq(irq_full));

    // bare core: no query, alignment, virtual mode or optional ops
    feature_detect_and_opcode_trap #(
        .CAP_D(32'h0000_0000), .HAS_QUERY(1'h0), .HAS_ALIGN(1'h0),
        .HAS_VME(1'h0), .FAMILY(4'h3)
    ) u_bare (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata_bare), .dec_req(dec_req),
        .dec_res(res_bare), .irq(irq_bare));

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // word comparison
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // decode answer comparison
    task automatic cmp_res(input dec_res_t got, input dec_res_t exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one-cycle read, data checked in the following cycle
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e1,
        input logic [31:0] e2, input logic [31:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp32(rdata_full & m, e1);
        cmp32(rdata_bare & m, e2);
    endtask

    // interrupt levels of both cores
    task automatic irq_chk(input logic e1, input logic e2);
        @(negedge clk);
        cmp32({31'h0, irq_full}, {31'h0, e1});
        cmp32({31'h0, irq_bare}, {31'h0, e2});
    endtask

    // one decode request, answer one cycle later
    task automatic decode(input logic [9:0] row);
        dec_res_t ok;
        dec_res_t bad;
        ok = '{valid: 1'b1, fault: 1'b0, exec: 1'b1};
        bad = '{valid: 1'b1, fault: 1'b1, exec: 1'b0};
        @(posedge clk);
        dec_req <= '{valid: 1'b1, cls: op_class_t'(row[8:4]),
            sub: row[3:0]};
        @(posedge clk);
        dec_req.valid <= 1'b0;
        @(negedge clk);
        cmp_res(res_full, row[9] ? ok : bad);
        // bare core accepts only the base class
        cmp_res(res_bare, (row[8:4] == OPC_BASE) ? ok : bad);
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycle_cnt++;
        if (cycle_cnt == 5000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // main sequence
    initial
    begin
        err_total = 0;
        check_count = 0;
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        dec_req = '0;
        tab = '{{1'b1, OPC_BASE, 4'h0}, {1'b0, OPC_RESERVED, 4'h0},
            {1'b1, OPC_CMOV, 4'h0}, {1'b1, OPC_FLOAT_CONDITIONAL_MOVE, 4'h0},
            {1'b1, OPC_FLOAT_COMPARE_TO_FLAGS, 4'h0}, {1'b1, OPC_PERF_READ, 4'h0},
            {1'b0, OPC_UNDEF_OP, 4'h0}, {1'b1, OPC_CMPXCHG8, 4'h0},
            {1'b1, OPC_QUERY, 4'h0}, {1'b1, OPC_TSC, 4'h0},
            {1'b1, OPC_MODEL_RD, 4'h0}, {1'b1, OPC_MODEL_WR, 4'h0},
            {1'b1, OPC_PACKED_INT, 4'h0}, {1'b0, OPC_TEST_REG_MOV, 4'h0},
            {1'b1, OPC_VEC1, 4'h0}, {1'b1, OPC_VEC2, 4'h0},
            {1'b1, OPC_VEC3, 4'hC}, {1'b0, OPC_VEC3, 4'hD}};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // reset values and feature reports
        reg_read(`ADDR_FLAGS, 32'h0, 32'h0, 32'hFFFF_FFFF);
        reg_read(`ADDR_STATUS, 32'h0, 32'h0, 32'hFFFF_FFFF);
        reg_read(`ADDR_QUERY_D, 32'h0E80_8131, 32'h0,
            32'hFFFF_FFFF);
        reg_read(`ADDR_QUERY_A, 32'h0A00, 32'h0300, 32'h0F00);
        irq_chk(1'b0, 1'b0);
        // flag bits: gate, virtual and alignment only where present
        reg_write(`ADDR_FLAGS, 32'hFFFF_FFFF);
        reg_read(`ADDR_FLAGS, 32'h003F_FFFF, 32'h0003_FFFF,
            32'hFFFF_FFFF);
        reg_write(`ADDR_FLAGS, 32'h0000_0000);
        reg_read(`ADDR_FLAGS, 32'h0, 32'h0, 32'hFFFF_FFFF);
        reg_write(`ADDR_FLAGS, 32'h0004_0000);
        reg_read(`ADDR_FLAGS, 32'h0004_0000, 32'h0,
            32'hFFFF_FFFF);
        reg_write(`ADDR_FLAGS, 32'h0018_0000);
        reg_read(`ADDR_FLAGS, 32'h0018_0000, 32'h0,
            32'hFFFF_FFFF);
        reg_read(`ADDR_STATUS, 32'h4, 32'h0, 32'hFFFF_FFFF);
        // every class, including an out-of-range third-set op
        foreach (tab[i])
            decode(tab[i]);
        reg_read(`ADDR_FAULT_CNT, 32'h4, 32'h11, 32'hFFFF);
        reg_read(`ADDR_STATUS, 32'h7, 32'h3, 32'hFFFF_FFFF);
        irq_chk(1'b0, 1'b0);
        // unmask, clear, unmask all, clear all
        reg_write(`ADDR_MASK, 32'h1);
        irq_chk(1'b1, 1'b1);
        reg_write(`ADDR_STATUS, 32'h1);
        irq_chk(1'b0, 1'b0);
        reg_read(`ADDR_STATUS, 32'h6, 32'h2, 32'hFFFF_FFFF);
        reg_write(`ADDR_MASK, 32'h7);
        irq_chk(1'b1, 1'b1);
        reg_write(`ADDR_STATUS, 32'h7);
        irq_chk(1'b0, 1'b0);
        reg_read(`ADDR_STATUS, 32'h0, 32'h0, 32'hFFFF_FFFF);
        // last vector register, top word, and control word
        reg_write(8'hFC, 32'h89AB_CDEF);
        reg_read(8'hFC, 32'h89AB_CDEF, 32'h0, 32'hFFFF_FFFF);
        reg_write(8'h80, 32'h1234_5678);
        reg_read(8'h80, 32'h1234_5678, 32'h0, 32'hFFFF_FFFF);
        reg_write(`ADDR_VEC_CSR, 32'h0000_1F80);
        reg_read(8'hFC, 32'h89AB_CDEF, 32'h0, 32'hFFFF_FFFF);
        reg_read(`ADDR_VEC_CSR, 32'h1F80, 32'h0, 32'hFFFF_FFFF);
        // unmapped and read-only places
        reg_write(8'h40, 32'hFFFF_FFFF);
        reg_read(8'h40, 32'h0, 32'h0, 32'hFFFF_FFFF);
        reg_write(`ADDR_QUERY_D, 32'h0);
        reg_read(`ADDR_QUERY_D, 32'h0E80_8131, 32'h0,
            32'hFFFF_FFFF);
        report_and_stop();
    end
endmodule
